//--- inc/sigc_pkg.sv
// Constants shared by the socket interrupt and general control block.
// Assumes an 8-bit register port and a 12-bit socket-relative address.
package sigc_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int SEL_W = 4;
	localparam int LINE_COUNT = 16;

	// ****************************************
	// Register map
	// ****************************************
	// Legacy socket space offset and socket window offset of the control register
	localparam logic [ADDR_W-1:0] OFS_LEGACY_CTRL = 12'h003;
	localparam logic [ADDR_W-1:0] OFS_SOCKET_CTRL = 12'h803;
	localparam logic [DATA_W-1:0] CTRL_RESET_VAL = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

	// ****************************************
	// Field positions of the control register
	// ****************************************
	localparam int BIT_RING_EN = 7;
	localparam int BIT_RESET_REL = 6;
	localparam int BIT_KIND_IO = 5;
	localparam int BIT_PCI_ROUTE = 4;
	localparam int SEL_HI = 3;
	localparam int SEL_LO = 0;

	// ****************************************
	// Interrupt select codes
	// ****************************************
	localparam logic [SEL_W-1:0] CODE_NONE = 4'h0;
	localparam logic [SEL_W-1:0] CODE_MGMT_IRQ = 4'h2;
	localparam logic [SEL_W-1:0] CODE_FIRST_NUMERIC = 4'h3;
	// Lines reachable by numeric code; 0 means no routing, 2 is the management interrupt code
	localparam logic [LINE_COUNT-1:0] LINE_VALID_MASK = 16'hFFFA;
	localparam logic [LINE_COUNT-1:0] LINE_ONE = 16'h0001;
endpackage

//--- core/sigc_route.sv
// Registered router from a 4-bit select code to legacy lines or the management interrupt.
// Assumes req is a level synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module sigc_route
	import sigc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic req,
	input wire logic [sigc_pkg::SEL_W-1:0] code,
	output logic [sigc_pkg::LINE_COUNT-1:0] line_reg,
	output logic mgmt_reg
);
	import sigc_pkg::*;

	// ****************************************
	// Decode
	// ****************************************
	function automatic logic [LINE_COUNT-1:0] line_of(input logic [SEL_W-1:0] c);
		logic [LINE_COUNT-1:0] one;
		one = LINE_ONE << c;
		return one & LINE_VALID_MASK;
	endfunction

	logic [LINE_COUNT-1:0] line_next;
	logic mgmt_next;

	always_comb
	begin
		// RQ7 numeric lines
		// RQ10 code equals line
		line_next = req ? line_of(code) : '0;
		// RQ7 management interrupt code
		mgmt_next = req && (code == CODE_MGMT_IRQ);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			line_reg <= '0;
			mgmt_reg <= 1'b0;
		end
		else
		begin
			line_reg <= line_next;
			mgmt_reg <= mgmt_next;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_line_onehot: assert property ($onehot0(line_reg) && !(mgmt_reg && |line_reg)) // RQ7
		else $error("router drives more than one destination");
	chk_mgmt_code: assert property (req && code == CODE_MGMT_IRQ |=> mgmt_reg && line_reg == '0) // RQ7
		else $error("management code did not reach the management interrupt alone");
	chk_none_code: assert property (req && code == CODE_NONE |=> !mgmt_reg && line_reg == '0) // RQ6
		else $error("zero code routed an interrupt");
	chk_numeric_line: assert property (req && code >= CODE_FIRST_NUMERIC |=> line_reg[$past(code)]) // RQ10
		else $error("numeric code missed its line");
endmodule // sigc_route
`default_nettype wire

//--- core/sigc_ctrl.sv
// Socket interrupt and general control register with its routing logic.
// Assumes register strobes and card pins synchronous to clk, host clock domain.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RQ1: Bit 7 turns the battery-detect-one pin into a ring indicate input.
// RQ2: Bit 6 zero holds card reset asserted; one releases it.
// RQ3: Software reset bit acts on 16-bit cards only, never 32-bit ones.
// RQ4: Bit 5 gives card kind: zero memory card, one I/O card.
// RQ5: Bit 4 set sends status-change interrupts to PCI, else to select field.
// RQ6: Select code zero routes no functional interrupt; ORed with PCI routing bit.
// RQ7: Bits 3..0 pick functional destination; 0001 line 1, 0010 management interrupt.
// RQ8: Register read/write at legacy 03h and socket 803h; resets to 00h.
// RQ9: Under ring operation status bit 0 shows ring indicate, not battery dead.
// RQ10: Other codes route to the line of equal number; reserved codes route nowhere.
module sigc_ctrl
	import sigc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_legacy_space,
	input wire logic [sigc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sigc_pkg::DATA_W-1:0] reg_wdata,
	output logic [sigc_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic card_is_16bit,
	input wire logic battery_detect_one,
	input wire logic battery_dead_status,
	input wire logic card_func_irq,
	input wire logic card_status_change,
	input wire logic [sigc_pkg::SEL_W-1:0] status_change_irq_select,
	output logic card_reset_16,
	output logic ring_indicate_active,
	output logic card_kind_select,
	output logic status_bit0,
	output logic status_change_pci_irq,
	output logic [sigc_pkg::LINE_COUNT-1:0] status_change_legacy_irq,
	output logic [sigc_pkg::LINE_COUNT-1:0] func_legacy_irq,
	output logic system_management_irq,
	output logic status_change_mgmt_irq
);
	import sigc_pkg::*;

	// ****************************************
	// Register port
	// ****************************************
	logic [DATA_W-1:0] ctrl_reg;
	logic ctrl_hit;
	logic ring_indicate_enable;
	logic status_change_pci_route;
	logic [SEL_W-1:0] card_irq_select;
	logic status_change_to_pci;

	// RQ8 both address spaces
	assign ctrl_hit = reg_legacy_space ? (reg_addr == OFS_LEGACY_CTRL)
		: (reg_addr == OFS_SOCKET_CTRL);

	assign ring_indicate_enable = ctrl_reg[BIT_RING_EN];
	assign status_change_pci_route = ctrl_reg[BIT_PCI_ROUTE];
	assign card_irq_select = ctrl_reg[SEL_HI:SEL_LO];

	// RQ8 write and reset
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_reg <= CTRL_RESET_VAL;
		else if (reg_wr && ctrl_hit)
			ctrl_reg <= reg_wdata;
	end

	// Read data registered; a read beside a write in one cycle sees the old value
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_rdata <= RDATA_UNMAPPED;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= ctrl_hit ? ctrl_reg : RDATA_UNMAPPED;
		end
	end

	// ****************************************
	// Card reset and card kind
	// ****************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			card_reset_16 <= 1'b0;
			card_kind_select <= 1'b0;
		end
		else
		begin
			// RQ2 reset level
			// RQ3 16-bit only
			card_reset_16 <= card_is_16bit && !ctrl_reg[BIT_RESET_REL];
			// RQ4 card kind
			card_kind_select <= ctrl_reg[BIT_KIND_IO];
		end
	end

	// ****************************************
	// Ring indicate
	// ****************************************
	// The pin is active low while it serves as ring indicate
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ring_indicate_active <= 1'b0;
			status_bit0 <= 1'b0;
		end
		else
		begin
			// RQ1 ring enable
			ring_indicate_active <= ring_indicate_enable && !battery_detect_one;
			// RQ9 status bit source
			status_bit0 <= ring_indicate_enable ? !battery_detect_one : battery_dead_status;
		end
	end

	// ****************************************
	// Status-change routing
	// ****************************************
	// RQ5 PCI routing bit
	// RQ6 zero code ORed
	assign status_change_to_pci = status_change_pci_route || (card_irq_select == CODE_NONE);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			status_change_pci_irq <= 1'b0;
		else
			status_change_pci_irq <= card_status_change && status_change_to_pci;
	end

	// RQ5 legacy select field
	sigc_route u_status_route
	(
		.clk(clk),
		.rst_b(rst_b),
		.req(card_status_change && !status_change_to_pci),
		.code(status_change_irq_select),
		.line_reg(status_change_legacy_irq),
		.mgmt_reg(status_change_mgmt_irq)
	);

	// ****************************************
	// Functional interrupt routing
	// ****************************************
	// Memory cards raise no functional interrupt, so the request is gated by kind
	// RQ7 functional destination
	sigc_route u_func_route
	(
		.clk(clk),
		.rst_b(rst_b),
		.req(card_func_irq && ctrl_reg[BIT_KIND_IO]),
		.code(card_irq_select),
		.line_reg(func_legacy_irq),
		.mgmt_reg(system_management_irq)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_write_store: assert property (reg_wr && ctrl_hit |=> ctrl_reg == $past(reg_wdata)) // RQ8
		else $error("control write not stored");
	chk_read_back: assert property (reg_wr && ctrl_hit ##1 reg_rd && !reg_wr && ctrl_hit |=> // RQ8
		reg_rvalid && reg_rdata == $past(reg_wdata, 2))
		else $error("control read did not return written value");
	chk_unmapped_read: assert property (reg_rd && !ctrl_hit |=> reg_rvalid && reg_rdata == '0) // RQ8
		else $error("unmapped read not zero");
	chk_reset_level: assert property (card_is_16bit && !ctrl_reg[BIT_RESET_REL] |=> card_reset_16) // RQ2
		else $error("card reset not asserted");
	chk_reset_scope: assert property (!card_is_16bit |=> !card_reset_16) // RQ3
		else $error("software reset reached a 32-bit card");
	chk_kind_follow: assert property (reg_wr && ctrl_hit |=> ##1 // RQ4
		card_kind_select == $past(reg_wdata[BIT_KIND_IO], 2))
		else $error("card kind output stale");
	chk_ring_gate: assert property (!ring_indicate_enable |=> !ring_indicate_active) // RQ1
		else $error("ring indicate active while disabled");
	chk_status_ring: assert property (ring_indicate_enable |=> // RQ9
		status_bit0 == !$past(battery_detect_one))
		else $error("status bit 0 ignores ring indicate");
	chk_status_pci: assert property (card_status_change && status_change_to_pci |=> // RQ5
		status_change_pci_irq ##1
		(status_change_legacy_irq == '0 || !$past(status_change_to_pci)))
		else $error("status change not sent to PCI");
	chk_status_zero: assert property (card_status_change && card_irq_select == CODE_NONE |=> // RQ6
		status_change_pci_irq)
		else $error("zero select code not ORed with PCI route");
	chk_func_mgmt: assert property (card_func_irq && ctrl_reg[BIT_KIND_IO] && // RQ7
		card_irq_select == CODE_MGMT_IRQ |=> system_management_irq)
		else $error("functional interrupt missed management interrupt");
endmodule // sigc_ctrl
`default_nettype wire

//--- tb/sigc_card_model.sv
// Behavioural 16-bit card in the socket, driving its pins on bench command.
// Assumes commands change just after the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module sigc_card_model
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ring_low,
	input wire logic func_req,
	input wire logic status_req,
	output logic battery_detect_one,
	output logic card_func_irq,
	output logic card_status_change
);
	// Pins settle one edge late, as a card output would
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			battery_detect_one <= 1'b1;
			card_func_irq <= 1'b0;
			card_status_change <= 1'b0;
		end
		else
		begin
			battery_detect_one <= ~ring_low;
			card_func_irq <= func_req;
			card_status_change <= status_req;
		end
	end
endmodule // sigc_card_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the socket control register and its routing.
// Assumes the card model on the pins and a 20 MHz host clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sigc_pkg::*;
	logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_legacy_space = 0;
	logic [11:0] reg_addr = 12'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, m_ctrl;
	logic card_is_16bit = 0, battery_dead_status = 0, ring_low = 0, func_req = 0, status_req = 0;
	logic [3:0] status_change_irq_select = 4'h0;
	logic reg_rvalid, battery_detect_one, card_func_irq, card_status_change, card_reset_16;
	logic ring_indicate_active, card_kind_select, status_bit0, status_change_pci_irq;
	logic system_management_irq, status_change_mgmt_irq;
	logic [15:0] status_change_legacy_irq, func_legacy_irq;
	logic [31:0] r = 32'h00010358;
	int miscompares = 0, n_checks = 0;
	sigc_card_model i_card (.clk(clk), .rst_b(rst_b), .ring_low(ring_low), .func_req(func_req),
		.status_req(status_req), .battery_detect_one(battery_detect_one),
		.card_func_irq(card_func_irq), .card_status_change(card_status_change));
	sigc_ctrl i_dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_legacy_space(reg_legacy_space), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .card_is_16bit(card_is_16bit),
		.battery_detect_one(battery_detect_one), .battery_dead_status(battery_dead_status),
		.card_func_irq(card_func_irq), .card_status_change(card_status_change),
		.status_change_irq_select(status_change_irq_select), .card_reset_16(card_reset_16),
		.ring_indicate_active(ring_indicate_active), .card_kind_select(card_kind_select),
		.status_bit0(status_bit0), .status_change_pci_irq(status_change_pci_irq),
		.status_change_legacy_irq(status_change_legacy_irq), .func_legacy_irq(func_legacy_irq),
		.system_management_irq(system_management_irq),
		.status_change_mgmt_irq(status_change_mgmt_irq));
	initial
	begin
		forever #25 clk = ~clk;
	end
	// ****************************************
	// Reference model and compares
	// ****************************************
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Codes 0 and 2 never reach a numbered line
	function automatic logic [15:0] dec(logic [3:0] c);
		return (c == 4'h0 || c == 4'h2) ? 16'h0000 : 16'h0001 << c;
	endfunction
	task automatic cmp(string name, logic [15:0] exp, logic [15:0] seen);
		n_checks++;
		if (exp !== seen)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic check_outs();
		logic pci;
		logic chg;
		logic fn;
		logic chg_mgmt;
		logic [15:0] chg_lines;
		pci = m_ctrl[4] | (m_ctrl[3:0] == 4'h0);
		chg = status_req;
		fn = func_req & m_ctrl[5];
		chg_lines = (chg & ~pci) ? dec(status_change_irq_select) : 16'h0000;
		chg_mgmt = chg & ~pci & (status_change_irq_select == 4'h2);
		cmp("reset", 16'(card_is_16bit & ~m_ctrl[6]), 16'(card_reset_16));
		cmp("ring", 16'(m_ctrl[7] & ring_low), 16'(ring_indicate_active));
		cmp("stat0", 16'(m_ctrl[7] ? ring_low : battery_dead_status), 16'(status_bit0));
		cmp("kind", 16'(m_ctrl[5]), 16'(card_kind_select));
		cmp("chgpci", 16'(chg & pci), 16'(status_change_pci_irq));
		cmp("chglines", chg_lines, status_change_legacy_irq);
		cmp("chgmgmt", 16'(chg_mgmt), 16'(status_change_mgmt_irq));
		cmp("funclines", fn ? dec(m_ctrl[3:0]) : 16'h0000, func_legacy_irq);
		cmp("funcmgmt", 16'(fn & (m_ctrl[3:0] == 4'h2)), 16'(system_management_irq));
	endtask
	// ****************************************
	// Register port tasks
	// ****************************************
	task automatic wr(logic sp, logic [11:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_legacy_space <= sp;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		if ((sp && a == 12'h003) || (!sp && a == 12'h803))
			m_ctrl = d;
	endtask
	task automatic rd(logic sp, logic [11:0] a, logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_legacy_space <= sp;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		cmp("rvalid", 16'h0001, 16'(reg_rvalid));
		cmp("rdata", 16'(exp), 16'(reg_rdata));
	endtask
	// Read strobe rises on the edge that takes the write, so the read sees the new value
	task automatic wr_rd(logic sp, logic [11:0] a, logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_legacy_space <= sp;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		m_ctrl = d;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		cmp("rvalid", 16'h0001, 16'(reg_rvalid));
		cmp("rdata", 16'(d), 16'(reg_rdata));
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		m_ctrl = 8'h00;
	endtask
	task automatic finish_test();
		if (miscompares == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#2000000;
		miscompares++;
		finish_test();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		do_reset();
		rd(1'b1, 12'h003, 8'h00);
		for (int i = 0; i < 48; i++)
		begin
			r = lfsr(r);
			@(posedge clk);
			{card_is_16bit, battery_dead_status, ring_low} <= r[15:13];
			status_change_irq_select <= r[19:16];
			status_req <= r[20];
			func_req <= (i < 16) | r[21];
			wr(r[12], r[12] ? 12'h003 : 12'h803, {r[7:6], r[5] | (i < 16), r[4], 4'(i)});
			wr(r[22], 12'h004, r[30:23]);
			rd(~r[12], r[12] ? 12'h803 : 12'h003, m_ctrl);
			rd(r[22], 12'h004, RDATA_UNMAPPED);
			repeat (4) @(posedge clk);
			@(negedge clk);
			check_outs();
		end
		r = lfsr(r);
		wr_rd(r[12], r[12] ? 12'h003 : 12'h803, r[7:0]);
		repeat (4) @(posedge clk);
		@(negedge clk);
		check_outs();
		do_reset();
		rd(1'b0, 12'h803, CTRL_RESET_VAL);
		repeat (4) @(posedge clk);
		@(negedge clk);
		check_outs();
		finish_test();
	end
endmodule // testbench
`default_nettype wire
